// [dlx_guard.sv]
// Host-side guard that spaces memory commands around calibration and low-power modes
`timescale 1ns/100ps
module dlx_guard #(
  parameter int INIT_CAL = dlx_pkg::INIT_CAL_CYC,
  parameter int LOOP_LOCK = dlx_pkg::LOOP_LOCK_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic req_valid,              // User requests an operation
  input wire dlx_pkg::dlx_req_t req,       // Operation and its command class
  input wire logic parity_on,              // Command/address parity enabled
  output logic req_ready,                  // Operation accepted this cycle
  output dlx_pkg::dlx_pins_t pins          // Registered pin drive
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum {ST_UP, ST_ACTIVE, ST_SR, ST_PD, ST_PS} dlx_state_t;
  dlx_state_t state_ff;                    // Memory power state
  logic [dlx_pkg::CNT_W-1:0] plain_ff;     // Window before plain commands
  logic [dlx_pkg::CNT_W-1:0] calmrs_ff;    // Window before calibration/mode writes
  logic [dlx_pkg::CNT_W-1:0] locked_ff;    // Window before locked-loop commands
  logic [dlx_pkg::CNT_W-1:0] low_ff;       // Clock-enable low width window
  logic [dlx_pkg::CNT_W-1:0] clk_ff;       // Clock hold after entry window
  logic [dlx_pkg::CNT_W-1:0] lead_ff;      // Clock running before exit
  dlx_pkg::dlx_pins_t pins_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [dlx_pkg::CNT_W-1:0] par_w = parity_on ?
    dlx_pkg::CNT_W'(dlx_pkg::PARITY_CYC) : '0;
  wire logic lead_ok = lead_ff >= dlx_pkg::CNT_W'(dlx_pkg::CKS_CYC);
  wire logic cls_ok = (plain_ff == '0) &&
    (req.cls != dlx_pkg::DLX_CLS_CALMRS || calmrs_ff == '0) &&
    (req.cls != dlx_pkg::DLX_CLS_LOCKED || locked_ff == '0);
  wire logic is_exit = req.op == dlx_pkg::DLX_OP_SR_EXIT ||
    req.op == dlx_pkg::DLX_OP_PD_EXIT || req.op == dlx_pkg::DLX_OP_PS_EXIT;
  wire logic is_entry = req.op == dlx_pkg::DLX_OP_SR_ENTRY ||
    req.op == dlx_pkg::DLX_OP_PD_ENTRY || req.op == dlx_pkg::DLX_OP_PS_ENTRY;
  wire logic state_ok =
    (state_ff == ST_UP) ? req.op == dlx_pkg::DLX_OP_RESET_EXIT && lead_ok :
    (state_ff == ST_ACTIVE) ? !is_exit && req.op != dlx_pkg::DLX_OP_RESET_EXIT && cls_ok :
    (state_ff == ST_SR) ? req.op == dlx_pkg::DLX_OP_SR_EXIT && low_ff == '0 &&
                          clk_ff == '0 && lead_ok :
    (state_ff == ST_PD) ? req.op == dlx_pkg::DLX_OP_PD_EXIT && clk_ff == '0 && lead_ok :
    req.op == dlx_pkg::DLX_OP_PS_EXIT && clk_ff == '0 && lead_ok;
  // A request waits while plain_ff or the window of its own class is open; meanwhile only deselects go out
  assign req_ready = req_valid && req.op != dlx_pkg::DLX_OP_NONE && state_ok;
  wire logic take = req_ready;
  wire logic clk_run = clk_ff != '0 || !(state_ff == ST_SR || state_ff == ST_PD ||
    state_ff == ST_PS) || (take && is_exit) || (req_valid && is_exit);
  assign pins = pins_ff;

  // Down counter step
  function automatic logic [dlx_pkg::CNT_W-1:0] dec(input logic [dlx_pkg::CNT_W-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction : dec

  // Larger of a running window and a new load
  function automatic logic [dlx_pkg::CNT_W-1:0] ld(input logic [dlx_pkg::CNT_W-1:0] v,
                                                  input logic [dlx_pkg::CNT_W-1:0] n);
    return (n > v) ? n : v;
  endfunction : ld

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  logic [dlx_pkg::CNT_W-1:0] nxt_plain, nxt_calmrs, nxt_locked, nxt_low, nxt_clk;
  dlx_state_t nxt_state;
  always_comb begin
    nxt_plain = dec(plain_ff);
    nxt_calmrs = dec(calmrs_ff);
    nxt_locked = dec(locked_ff);
    nxt_low = dec(low_ff);
    nxt_clk = dec(clk_ff);
    nxt_state = state_ff;
    if (take) begin
      unique case (req.op)
        dlx_pkg::DLX_OP_RESET_EXIT: begin
          nxt_state = ST_ACTIVE;
          nxt_plain = dlx_pkg::CNT_W'(dlx_pkg::RESET_EXIT_CYC + INIT_CAL);
        end
        dlx_pkg::DLX_OP_FULL_CAL: nxt_plain = ld(nxt_plain, dlx_pkg::CNT_W'(dlx_pkg::FULL_CAL_CYC));
        dlx_pkg::DLX_OP_SHORT_CAL: nxt_plain = ld(nxt_plain, dlx_pkg::CNT_W'(dlx_pkg::SHORT_CAL_CYC));
        dlx_pkg::DLX_OP_SR_ENTRY: begin
          nxt_state = ST_SR;
          nxt_low = dlx_pkg::CNT_W'(dlx_pkg::CKE_MIN_CYC + 1) + par_w;
          nxt_clk = dlx_pkg::CNT_W'(dlx_pkg::CKS_CYC) + par_w;
        end
        dlx_pkg::DLX_OP_PD_ENTRY: begin
          nxt_state = ST_PD;
          nxt_clk = dlx_pkg::CNT_W'(dlx_pkg::CKS_CYC) + par_w;
        end
        dlx_pkg::DLX_OP_PS_ENTRY: begin
          nxt_state = ST_PS;
          nxt_clk = dlx_pkg::CNT_W'(dlx_pkg::PS_HOLD_CYC);
        end
        dlx_pkg::DLX_OP_SR_EXIT: begin
          nxt_state = ST_ACTIVE;
          nxt_plain = dlx_pkg::CNT_W'(dlx_pkg::SR_EXIT_CYC);
          nxt_calmrs = dlx_pkg::CNT_W'(dlx_pkg::FAST_EXIT_CYC);
          nxt_locked = dlx_pkg::CNT_W'(LOOP_LOCK);
        end
        dlx_pkg::DLX_OP_PD_EXIT: nxt_state = ST_ACTIVE;
        dlx_pkg::DLX_OP_PS_EXIT: begin
          nxt_state = ST_ACTIVE;
          nxt_plain = dlx_pkg::CNT_W'(dlx_pkg::PS_EXIT_CYC);
          nxt_locked = dlx_pkg::CNT_W'(dlx_pkg::PS_EXIT_CYC + LOOP_LOCK);
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Window counters and power state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_UP;
      plain_ff <= '0;
      calmrs_ff <= '0;
      locked_ff <= '0;
      low_ff <= '0;
      clk_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      plain_ff <= nxt_plain;
      calmrs_ff <= nxt_calmrs;
      locked_ff <= nxt_locked;
      low_ff <= nxt_low;
      clk_ff <= nxt_clk;
    end
  end

  // Count cycles of running clock, saturating; cleared when clock stops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lead_ff <= '0;
    end else if (!pins_ff.clk_en) begin
      lead_ff <= '0;
    end else if (lead_ff != '1) begin
      lead_ff <= lead_ff + 1'b1;
    end
  end

  // Pin drive: deselect unless a request is taken
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pins_ff <= '{cke: 1'b0, clk_en: 1'b1, cmd_valid: 1'b0, cmd: dlx_pkg::DLX_OP_NONE};
    end else begin
      pins_ff.cke <= (nxt_state == ST_ACTIVE);
      pins_ff.clk_en <= clk_run;
      pins_ff.cmd_valid <= take && !is_entry;
      pins_ff.cmd <= take ? req.op : dlx_pkg::DLX_OP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FULL_CAL: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == dlx_pkg::DLX_OP_FULL_CAL |=> !req_ready [*8])
    else $error("command taken too soon after full calibration");
  AST_SHORT_CAL: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == dlx_pkg::DLX_OP_SHORT_CAL |=> plain_ff == 12'h080)
    else $error("short calibration window wrong");
  AST_SR_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == dlx_pkg::DLX_OP_SR_ENTRY |=> ##1 !pins_ff.cke [*4])
    else $error("clock enable rose early after self refresh entry");
  AST_CLK_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == dlx_pkg::DLX_OP_PD_ENTRY |=> ##1 pins_ff.clk_en [*5])
    else $error("clock stopped early after entry");
  AST_EXIT_LEAD: assert property (@(posedge core_clk) disable iff (!resetn)
    take && is_exit |-> $past(pins_ff.clk_en, 1) && $past(pins_ff.clk_en, 5) &&
      lead_ff >= 12'h005)
    else $error("exit without clock lead");
  AST_PS_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    take && req.op == dlx_pkg::DLX_OP_PS_ENTRY |=> clk_ff == 12'h01c)
    else $error("power save clock hold wrong");
  AST_LOCKED: assert property (@(posedge core_clk) disable iff (!resetn)
    req_ready && req.cls == dlx_pkg::DLX_CLS_LOCKED |-> locked_ff == '0)
    else $error("locked command inside lock window");
  AST_DESELECT: assert property (@(posedge core_clk) disable iff (!resetn)
    plain_ff != '0 |=> !pins_ff.cmd_valid || $past(is_exit) || $past(state_ff) != ST_ACTIVE)
    else $error("command issued while window open");

endmodule : dlx_guard

// [dlx_pkg.sv]
// Package with constants and types for the low-power and calibration timing guard
package dlx_pkg;

  // ----------------------------------------------------------------
  // Clock and time figures
  // ----------------------------------------------------------------
  localparam int CLK_PS = 40000;            // Core clock period in ps
  localparam int REF_EXTRA_NS = 10;         // Added to refresh cycle times
  localparam int MOD_NS = 15;               // Mode update floor in ns
  localparam int CKE_NS = 5;                // Clock-enable pulse floor in ns
  localparam int CKS_NS = 10;               // Clock valid floor in ns
  localparam int REFC_NS = 260;             // Refresh cycle time in ns
  localparam int REFC4_NS = 160;            // Fine 4x refresh cycle time in ns

  // Rounded-up cycle count of a time in ns
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns2cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int INIT_CAL_CYC = 1024;       // initial_calibration_wait
  localparam int FULL_CAL_CYC = 512;        // full_calibration_wait
  localparam int SHORT_CAL_CYC = 128;       // short_calibration_wait
  localparam int LOOP_LOCK_CYC = 768;       // loop_lock_time
  localparam int CPD_CYC = 4;               // command_pass_off_delay
  localparam int PARITY_CYC = 4;            // parity_latency
  localparam int MOD_CYC = max2(24, ns2cyc(MOD_NS));
  localparam int CKE_MIN_CYC = max2(3, ns2cyc(CKE_NS));
  localparam int CKS_CYC = max2(5, ns2cyc(CKS_NS));
  localparam int RESET_EXIT_CYC = max2(5, ns2cyc(REFC_NS + REF_EXTRA_NS));
  localparam int SR_EXIT_CYC = ns2cyc(REFC_NS + REF_EXTRA_NS);
  localparam int FAST_EXIT_CYC = ns2cyc(REFC4_NS + REF_EXTRA_NS);
  localparam int PS_HOLD_CYC = MOD_CYC + CPD_CYC;
  localparam int PS_EXIT_CYC = 1;           // Power-save exit delay, no figure given
  localparam int CNT_W = 12;                // Window counter width

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DLX_OP_NONE, DLX_OP_RESET_EXIT, DLX_OP_FULL_CAL, DLX_OP_SHORT_CAL,
    DLX_OP_SR_ENTRY, DLX_OP_SR_EXIT, DLX_OP_PD_ENTRY, DLX_OP_PD_EXIT,
    DLX_OP_PS_ENTRY, DLX_OP_PS_EXIT, DLX_OP_OTHER
  } dlx_op_t;

  typedef enum logic [1:0] {DLX_CLS_PLAIN, DLX_CLS_CALMRS, DLX_CLS_LOCKED} dlx_cls_t;

  // Request from the user side
  typedef struct packed {
    dlx_op_t op;
    dlx_cls_t cls;
  } dlx_req_t;

  // Pin state driven toward the memory
  typedef struct packed {
    logic cke;
    logic clk_en;
    logic cmd_valid;
    dlx_op_t cmd;
  } dlx_pins_t;

endpackage : dlx_pkg

// [dlx_mem_model.sv]
// Behavioural memory model that watches the guard's pin drive
`timescale 1ns/100ps
module dlx_mem_model #(
  parameter int READ_LAT = 11,  // Read latency in cycles, plain default
  parameter int BURST_LEN = 8   // Burst length in beats, plain default
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire dlx_pkg::dlx_pins_t pins,
  output logic path_off_ff,     // Command path disabled in power save
  output logic strobe_oe_ff,    // Read strobe out of high impedance
  output int viol_ff            // Commands seen on a stopped clock, or other than power-save exit on a stopped path, plus clock stops before the path is off
);
  int ps_cnt_ff;  // Cycles spent in power save
  logic ps_on_ff; // Power save entered and not yet left
  // Power save holds from the entry command until clock-enable rises again
  wire logic ps_in = !pins.cke && (ps_on_ff || pins.cmd == dlx_pkg::DLX_OP_PS_ENTRY);
  int rd_cnt_ff;  // Cycles since last read-class command, -1 before the first, held at 64 after
  // ----------------------------------------------------------------
  // Power-save path, strobe window and stray command count
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ps_cnt_ff <= 0;
      ps_on_ff <= 1'b0;
      rd_cnt_ff <= -1;
      path_off_ff <= 1'b0;
      strobe_oe_ff <= 1'b0;
      viol_ff <= 0;
    end else begin
      // Count cycles while power save holds
      ps_on_ff <= ps_in;
      ps_cnt_ff <= ps_in ? ps_cnt_ff + 1 : 0;
      path_off_ff <= ps_in && ps_cnt_ff >= dlx_pkg::PS_HOLD_CYC - 1;
      // Strobe window from latency-1 to latency+burst/2
      if (pins.cmd_valid && pins.cmd == dlx_pkg::DLX_OP_OTHER) begin
        rd_cnt_ff <= 0;
      end else if (rd_cnt_ff >= 0 && rd_cnt_ff < 64) begin
        rd_cnt_ff <= rd_cnt_ff + 1;
      end
      strobe_oe_ff <= rd_cnt_ff >= READ_LAT - 1 && rd_cnt_ff < READ_LAT + BURST_LEN / 2;
      // A command on a stopped clock, a command other than power-save exit on a disabled path, or a clock stopped early, is a fault
      if ((pins.cmd_valid && (!pins.clk_en ||
          (path_off_ff && pins.cmd != dlx_pkg::DLX_OP_PS_EXIT))) ||
          (ps_on_ff && !path_off_ff && !pins.clk_en)) begin
        viol_ff <= viol_ff + 1;
      end
    end
  end
endmodule : dlx_mem_model

// [dlx_guard_test.sv]
// Self-checking testbench of the command spacing guard
`timescale 1ns/100ps
module dlx_guard_test;
  localparam int LK = 16;  // Shortened initial calibration and loop lock counts
  localparam int RD_LAT = 11;  // Read latency given to the memory model
  localparam int BURST = 8;  // Burst length given to the memory model
  logic core_clk, resetn, req_valid, parity_on, req_ready, path_off, strobe_oe;
  dlx_pkg::dlx_req_t req;
  dlx_pkg::dlx_pins_t pins;
  dlx_pkg::dlx_op_t prev_op, op, ex;
  dlx_pkg::dlx_cls_t prev_cls, cls;
  dlx_pkg::dlx_op_t ops[3] = '{dlx_pkg::DLX_OP_SHORT_CAL, dlx_pkg::DLX_OP_FULL_CAL,
    dlx_pkg::DLX_OP_OTHER};
  dlx_pkg::dlx_op_t ent[3] = '{dlx_pkg::DLX_OP_SR_ENTRY, dlx_pkg::DLX_OP_PD_ENTRY,
    dlx_pkg::DLX_OP_PS_ENTRY};
  int viol, err_count, samples_checked, last, gap, n, m, rc, lc, par;
  int cyc = 0, run_cnt = 0, low_cnt = 0;  // Owned by the counter process only
  int seed = 32'hd8667c13;
  dlx_guard #(.INIT_CAL(LK), .LOOP_LOCK(LK)) u_dut (.core_clk(core_clk), .resetn(resetn),
    .req_valid(req_valid), .req(req), .parity_on(parity_on), .req_ready(req_ready),
    .pins(pins));
  dlx_mem_model #(.READ_LAT(RD_LAT), .BURST_LEN(BURST)) u_mem (.core_clk(core_clk),
    .resetn(resetn), .pins(pins),
    .path_off_ff(path_off), .strobe_oe_ff(strobe_oe), .viol_ff(viol));
  // Clock and cycle, clock-run and clock-enable-low counters
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    run_cnt <= (pins.clk_en === 1'b1) ? run_cnt + 1 : 0;
    low_cnt <= (pins.cke === 1'b0) ? low_cnt + 1 : 0;
  end
  // ----------------------------------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------------------------------
  // Minimum spacing after an operation before a following command of a given class
  function automatic int need(input dlx_pkg::dlx_op_t p, input dlx_pkg::dlx_cls_t c);
    case (p)
      dlx_pkg::DLX_OP_RESET_EXIT: return dlx_pkg::RESET_EXIT_CYC + LK;
      dlx_pkg::DLX_OP_FULL_CAL: return dlx_pkg::FULL_CAL_CYC;
      dlx_pkg::DLX_OP_SHORT_CAL: return dlx_pkg::SHORT_CAL_CYC;
      dlx_pkg::DLX_OP_SR_EXIT: return (c == dlx_pkg::DLX_CLS_LOCKED) ? LK :
        (c == dlx_pkg::DLX_CLS_CALMRS) ? dlx_pkg::FAST_EXIT_CYC : dlx_pkg::SR_EXIT_CYC;
      dlx_pkg::DLX_OP_PS_EXIT: return (c == dlx_pkg::DLX_CLS_LOCKED) ?
        dlx_pkg::PS_EXIT_CYC + LK : 1;
      default: return 1;
    endcase
  endfunction : need
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_min(input int got, input int lo);
    samples_checked++;
    if (got < lo) begin
      err_count++;
      $display("wrong value at %0t: got %h below %h", $time, got, lo);
    end
  endtask : chk_min
  // Offer a request and hold it until taken, then note gap and counters
  task automatic send(input dlx_pkg::dlx_op_t o, input dlx_pkg::dlx_cls_t c);
    int k;
    k = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{op: o, cls: c};
    @(negedge core_clk);
    while (req_ready !== 1'b1 && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
    @(posedge core_clk);
    gap = cyc - last;
    last = cyc;
    rc = run_cnt;
    lc = low_cnt;
    req_valid <= 1'b0;
    @(negedge core_clk);
    if (k >= 3000) chk(k, 0);
  endtask : send
  task automatic close_out;
    $display("checked %0d values, %0d mismatches", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req = '{op: dlx_pkg::DLX_OP_NONE, cls: dlx_pkg::DLX_CLS_PLAIN};
    parity_on = 1'b0;
    {last, err_count, samples_checked} = '0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk({pins.cke, pins.clk_en, pins.cmd_valid}, 3'b010);
    last = cyc;
    send(dlx_pkg::DLX_OP_RESET_EXIT, dlx_pkg::DLX_CLS_PLAIN);
    chk_min(rc + 1, dlx_pkg::CKS_CYC);
    chk({pins.cke, pins.cmd_valid, pins.cmd}, {2'b11, dlx_pkg::DLX_OP_RESET_EXIT});
    $display("test reset exit done");
    prev_op = dlx_pkg::DLX_OP_RESET_EXIT;
    prev_cls = dlx_pkg::DLX_CLS_PLAIN;
    // Fixed corner order first, then random calibration and other traffic
    for (int i = 0; i < 8; i++) begin
      op = (i < 3) ? ops[i] : ops[$unsigned($random(seed)) % 3];
      cls = dlx_pkg::dlx_cls_t'($unsigned($random(seed)) % 3);
      send(op, cls);
      chk_min(gap, need(prev_op, prev_cls));
      chk({pins.cmd_valid, pins.cmd}, {1'b1, op});
      prev_op = op;
      prev_cls = cls;
    end
    $display("test calibration spacing done");
    // Each low-power mode with each class of following command
    for (int e = 0; e < 3; e++) begin
      for (int c = 0; c < 3; c++) begin
        par = $unsigned($random(seed)) % 2;
        @(posedge core_clk);
        parity_on <= par[0];
        send(ent[e], dlx_pkg::DLX_CLS_PLAIN);
        chk_min(gap, need(prev_op, prev_cls));
        chk({pins.cke, pins.cmd}, {1'b0, ent[e]});
        n = 0;
        while (pins.clk_en === 1'b1 && n < 200) begin
          @(negedge core_clk);
          n++;
        end
        chk_min(n, (e == 2) ? dlx_pkg::PS_HOLD_CYC : dlx_pkg::CKS_CYC + par * 4);
        // Command path must be off by the time the clock stops in power save
        if (e == 2) chk(path_off, 1'b1);
        ex = dlx_pkg::dlx_op_t'(ent[e] + 1);
        send(ex, dlx_pkg::DLX_CLS_PLAIN);
        chk_min(rc + 1, dlx_pkg::CKS_CYC);
        if (e == 0) chk_min(lc + 1, dlx_pkg::CKE_MIN_CYC + 1 + par * 4);
        chk({pins.cke, pins.cmd_valid, pins.cmd}, {2'b11, ex});
        cls = dlx_pkg::dlx_cls_t'(c);
        send(dlx_pkg::DLX_OP_OTHER, cls);
        chk_min(gap, need(ex, cls));
        prev_op = dlx_pkg::DLX_OP_OTHER;
        prev_cls = cls;
      end
    end
    $display("test low power modes done");
    // Read strobe window; one cycle for the model to load rd_cnt_ff, one in the strobe_oe_ff register
    send(dlx_pkg::DLX_OP_OTHER, dlx_pkg::DLX_CLS_PLAIN);
    n = 0;
    while (strobe_oe !== 1'b1 && n < 64) begin
      @(negedge core_clk);
      n++;
    end
    m = 0;
    while (strobe_oe === 1'b1 && m < 64) begin
      @(negedge core_clk);
      m++;
    end
    chk(n, RD_LAT + 1);
    chk(m, BURST / 2 + 1);
    $display("test read strobe done");
    chk(viol, 0);
    // Mid-run reset returns the guard to its power-up windows
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk({pins.cke, pins.clk_en, pins.cmd_valid}, 3'b010);
    last = cyc;
    send(dlx_pkg::DLX_OP_RESET_EXIT, dlx_pkg::DLX_CLS_PLAIN);
    chk_min(rc + 1, dlx_pkg::CKS_CYC);
    send(dlx_pkg::DLX_OP_SHORT_CAL, dlx_pkg::DLX_CLS_PLAIN);
    chk_min(gap, need(dlx_pkg::DLX_OP_RESET_EXIT, dlx_pkg::DLX_CLS_PLAIN));
    chk({pins.cmd_valid, pins.cmd}, {1'b1, dlx_pkg::DLX_OP_SHORT_CAL});
    $display("test mid-run reset done");
    close_out();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("watchdog expired at %0t", $time);
    close_out();
  end
endmodule : dlx_guard_test
